// File: serial_eeprom_i2c_slave.v
// two-wire serial eeprom slave: bus engine, page buffer and array
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_regs.vh"
// Contract
// - the receiver pulls data low in the acknowledge clock after each byte
// - any start abandons the transfer and waits for a slave address; write_pending survives a start, so a later stop still programs
// - standby at power-up until a line toggles, after stop, after write
// - slave address is eight bits; top four must match device type
// - chip-select address bits unused for blocks must match select pins
// - remaining select bits pick the 256-byte block
// - address lsb one means read, zero means write
// - on match the device acknowledges on the ninth clock
// - byte write: address, word address, one data byte, each acked
// - programming starts at stop; bus ignored until it ends
// - page write takes up to sixteen data bytes, each acked
// - only the low four word-address bits advance on write bytes
// - bytes past sixteen wrap and overwrite earlier page bytes
// - all page bytes commit together in one timed cycle
// - no acknowledge while programming; master polls until acked
// - address counter holds last accessed address plus one
// - current read returns counter byte, top location wraps to zero
// - each master acknowledge yields the next byte; no ack ends it
// - sequential read wraps to zero after the top address
// - start is data falling while clock high; nothing before it
// - stop is data rising while clock high and ends the operation
// - write-protect high blocks all array writes; the code samples it only at the stop
// - unconnected chip-select pins count as zero; the code has no pull-down and samples the pins as driven
module serial_eeprom_i2c_slave #(
	parameter BLOCK_BITS   = 0,
	parameter WRITE_CYCLES = `EE_WRITE_CYCLES,
	parameter FIFO_DEPTH   = 8
) (
	// clock and reset
	input  wire clk_in,
	input  wire reset_n_in,
	// two-wire bus
	input  wire scl_in,
	input  wire sda_in,
	output reg  sda_out,
	output reg  sda_oe_n_out,
	// strap pins
	input  wire chip_select_pin_0_in,
	input  wire chip_select_pin_1_in,
	input  wire chip_select_pin_2_in,
	input  wire write_protect_in,
	// status
	output reg  standby_out,
	output reg  busy_out
);
	localparam AW        = 8 + BLOCK_BITS;
	localparam MEM_BYTES = 1 << AW;

	// slave address match against type code and select pins
	function dev_match;
		input [7:0] a;
		input [2:0] cs;
		integer i;
		begin
			dev_match = (a[`EE_TYPE_MSB:`EE_TYPE_LSB] == `EE_DEV_TYPE);
			for (i = 0; i < 3; i = i + 1)
				if (i >= BLOCK_BITS && a[`EE_SEL_LSB+i] != cs[i])
					dev_match = 1'b0;
		end
	endfunction

	reg  [7:0]    mem [0:MEM_BYTES-1];
	reg  [7:0]    page_buf [0:`EE_PAGE_BYTES-1];
	reg  [5:0]    sync1;
	reg  [5:0]    sync2;
	reg           scl_prev;
	reg           sda_prev;
	reg  [2:0]    state;
	reg  [3:0]    bitcnt;
	reg  [7:0]    rx;
	reg  [7:0]    tx;
	reg           got_byte;
	reg           ack_phase;
	reg  [2:0]    dev_blk;
	reg  [AW-1:0] addr_ptr;
	reg  [AW-1:0] page_base;
	reg           write_pending;
	reg  [15:0]   page_valid;
	reg           drained;
	reg  [16:0]   prog_cnt;
	reg  [1:0]    drain_cnt;
	reg           fifo_push;
	reg  [11:0]   fifo_wdata;
	reg  [10:0]   full_addr;
	wire          fifo_in_ready;
	wire          fifo_out_valid;
	wire [11:0]   fifo_rdata;
	wire          drain_en;
	wire          scl;
	wire          sda;
	wire [2:0]    cs;
	wire          wp;
	wire          scl_rise;
	wire          scl_fall;
	wire          start_cond;
	wire          stop_cond;
	wire          commit;
	integer       k;

	assign scl = sync2[0];
	assign sda = sync2[1];
	assign cs  = sync2[4:2];
	assign wp  = sync2[5];
	assign scl_rise   = scl & !scl_prev;
	assign scl_fall   = !scl & scl_prev;
	assign start_cond = scl & scl_prev & sda_prev & !sda;
	assign stop_cond  = scl & scl_prev & !sda_prev & sda;
	// loader runs on a divided enable, so a slow loader back-pressures
	// keeps draining while busy, so commit waits for the last byte
	assign drain_en = (drain_cnt == 2'h0);
	assign commit   = busy_out & !drained & !fifo_out_valid;

	always @* begin
		full_addr = {dev_blk, rx};
	end

	function [2:0] sync_blk;
		input [7:0] a;
		integer i;
		begin
			sync_blk = 3'h0;
			for (i = 0; i < BLOCK_BITS; i = i + 1)
				sync_blk[i] = a[`EE_SEL_LSB+i];
		end
	endfunction

	page_fifo #(
		.WIDTH (12),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_in        (clk_in),
		.reset_n_in    (reset_n_in),
		.in_valid_in   (fifo_push),
		.in_ready_out  (fifo_in_ready),
		.in_data_in    (fifo_wdata),
		.out_valid_out (fifo_out_valid),
		.out_ready_in  (drain_en),
		.out_data_out  (fifo_rdata)
	);

	// pins cross into the clock domain through two flops
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sync1    <= 6'h03;
			sync2    <= 6'h03;
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
		end else begin
			sync1    <= {write_protect_in, chip_select_pin_2_in,
				chip_select_pin_1_in, chip_select_pin_0_in, sda_in, scl_in};
			sync2    <= sync1;
			scl_prev <= scl;
			sda_prev <= sda;
		end
	end

	// array storage; every loaded page byte lands in one cycle
	always @(posedge clk_in) begin
		if (commit)
			for (k = 0; k < `EE_PAGE_BYTES; k = k + 1)
				if (page_valid[k])
					mem[{page_base[AW-1:4], k[3:0]}] <= page_buf[k];
	end

	always @(posedge clk_in) begin
		if (fifo_out_valid & drain_en)
			page_buf[fifo_rdata[11:8]] <= fifo_rdata[7:0];
	end

	// loader pacing divider and programming timer
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			drain_cnt <= 2'h0;
			drained   <= 1'b0;
			prog_cnt  <= 17'h00000;
		end else begin
			drain_cnt <= (drain_cnt == `EE_DRAIN_DIV - 1) ? 2'h0 :
				drain_cnt + 2'h1;
			if (!busy_out) begin
				drained  <= 1'b0;
				prog_cnt <= 17'h00000;
			end else if (commit) begin
				drained <= 1'b1;
			end else if (drained) begin
				prog_cnt <= prog_cnt + 17'h00001;
			end
		end
	end

	// bus engine
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state         <= `EE_ST_IDLE;
			bitcnt        <= 4'h0;
			rx            <= 8'h00;
			tx            <= 8'h00;
			got_byte      <= 1'b0;
			ack_phase     <= 1'b0;
			dev_blk       <= 3'h0;
			addr_ptr      <= {AW{1'b0}};
			page_base     <= {AW{1'b0}};
			write_pending <= 1'b0;
			page_valid    <= 16'h0000;
			fifo_push     <= 1'b0;
			fifo_wdata    <= 12'h000;
			sda_out       <= 1'b0;
			sda_oe_n_out  <= 1'b1;
			standby_out   <= 1'b1;
			busy_out      <= 1'b0;
		end else begin
			fifo_push <= 1'b0;
			if (fifo_out_valid & drain_en)
				page_valid[fifo_rdata[11:8]] <= 1'b1;
			if (standby_out & (scl != scl_prev || sda != sda_prev)
				& !busy_out)
				standby_out <= 1'b0;
			if (busy_out) begin
				// inputs ignored; polling gets no acknowledge
				sda_oe_n_out <= 1'b1;
				state        <= `EE_ST_IDLE;
				if (drained && prog_cnt == WRITE_CYCLES - 1) begin
					busy_out      <= 1'b0;
					standby_out   <= 1'b1;
					write_pending <= 1'b0;
					page_valid    <= 16'h0000;
				end
			end else if (start_cond) begin
				state        <= `EE_ST_DEV;
				bitcnt       <= 4'h0;
				got_byte     <= 1'b0;
				ack_phase    <= 1'b0;
				sda_oe_n_out <= 1'b1;
			end else if (stop_cond) begin
				state        <= `EE_ST_IDLE;
				sda_oe_n_out <= 1'b1;
				if (write_pending & !wp) begin
					busy_out <= 1'b1;
				end else begin
					write_pending <= 1'b0;
					page_valid    <= 16'h0000;
					standby_out   <= 1'b1;
				end
			end else if (state == `EE_ST_READ) begin
				if (scl_rise && ack_phase) begin
					if (sda)
						state <= `EE_ST_IDLE;
				end else if (scl_fall && ack_phase) begin
					ack_phase    <= 1'b0;
					tx           <= {mem[addr_ptr][6:0], 1'b0};
					sda_oe_n_out <= mem[addr_ptr][7];
					bitcnt       <= 4'h1;
					addr_ptr     <= addr_ptr + 1'b1;
				end else if (scl_fall) begin
					if (bitcnt == 4'h8) begin
						sda_oe_n_out <= 1'b1;
						ack_phase    <= 1'b1;
					end else begin
						sda_oe_n_out <= tx[7];
						tx           <= {tx[6:0], 1'b0};
						bitcnt       <= bitcnt + 4'h1;
					end
				end
			end else if (state != `EE_ST_IDLE) begin
				if (scl_rise && !ack_phase) begin
					rx     <= {rx[6:0], sda};
					bitcnt <= bitcnt + 4'h1;
					if (bitcnt == 4'h7)
						got_byte <= 1'b1;
				end else if (scl_fall && got_byte) begin
					got_byte  <= 1'b0;
					bitcnt    <= 4'h0;
					ack_phase <= 1'b1;
					case (state)
						`EE_ST_DEV: begin
							if (dev_match(rx, cs)) begin
								sda_oe_n_out <= 1'b0;
								// block bits come from the address byte
								dev_blk      <= sync_blk(rx);
								if (rx[`EE_RW_BIT]) begin
									state <= `EE_ST_READ;
								end else begin
									state <= `EE_ST_WORD;
								end
							end else begin
								state     <= `EE_ST_IDLE;
								ack_phase <= 1'b0;
							end
						end
						`EE_ST_WORD: begin
							// word address also serves random-read dummy write
							addr_ptr     <= full_addr[AW-1:0];
							page_base    <= full_addr[AW-1:0];
							page_valid   <= 16'h0000;
							sda_oe_n_out <= 1'b0;
							state        <= `EE_ST_WDATA;
						end
						`EE_ST_WDATA: begin
							if (fifo_in_ready) begin
								fifo_push     <= 1'b1;
								fifo_wdata    <= {addr_ptr[3:0], rx};
								write_pending <= 1'b1;
								sda_oe_n_out  <= 1'b0;
								addr_ptr      <= {addr_ptr[AW-1:4],
									addr_ptr[3:0] + 4'h1};
							end else begin
								// buffer full: refuse the byte
								state     <= `EE_ST_IDLE;
								ack_phase <= 1'b0;
							end
						end
						default: state <= `EE_ST_IDLE;
					endcase
				end else if (scl_fall && ack_phase) begin
					ack_phase    <= 1'b0;
					sda_oe_n_out <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// File: eeprom_regs.vh
// constants for the two-wire serial eeprom slave
`ifndef EEPROM_REGS_VH
`define EEPROM_REGS_VH
// clock rate in kHz and self-timed write time in ms
`define EE_CLK_KHZ       25000
`define EE_WRITE_TIME_MS 5
`define EE_WRITE_CYCLES  (`EE_WRITE_TIME_MS * `EE_CLK_KHZ)
// device-type code; the value is arbitrary
`define EE_DEV_TYPE      4'h5
// slave address fields
`define EE_TYPE_MSB      7
`define EE_TYPE_LSB      4
`define EE_SEL_LSB       1
`define EE_RW_BIT        0
// page size and array loader pacing
`define EE_PAGE_BYTES    16
`define EE_DRAIN_DIV     4
// bus states
`define EE_ST_IDLE       3'h0
`define EE_ST_DEV        3'h1
`define EE_ST_WORD       3'h2
`define EE_ST_WDATA      3'h3
`define EE_ST_READ       3'h4
`endif

// File: page_fifo.v
// small synchronous fifo between bus receiver and page buffer
`timescale 1ns/1ps
`default_nettype none
module page_fifo #(
	parameter WIDTH = 12,
	parameter DEPTH = 8
) (
	// clock and reset
	input  wire             clk_in,
	input  wire             reset_n_in,
	// filling side
	input  wire             in_valid_in,
	output wire             in_ready_out,
	input  wire [WIDTH-1:0] in_data_in,
	// draining side
	output wire             out_valid_out,
	input  wire             out_ready_in,
	output wire [WIDTH-1:0] out_data_out
);
	function integer clog2;
		input integer v;
		integer n;
		begin
			n = 0;
			while ((1 << n) < v) n = n + 1;
			clog2 = (n < 1) ? 1 : n;
		end
	endfunction

	localparam PW = clog2(DEPTH);

	reg [WIDTH-1:0] store [0:DEPTH-1];
	reg [PW-1:0]    wr_ptr;
	reg [PW-1:0]    rd_ptr;
	reg [PW:0]      count;
	wire            push;
	wire            pop;

	assign in_ready_out  = (count != DEPTH[PW:0]);
	assign out_valid_out = (count != {(PW+1){1'b0}});
	assign out_data_out  = store[rd_ptr];
	assign push = in_valid_in & in_ready_out;
	assign pop  = out_valid_out & out_ready_in;

	always @(posedge clk_in) begin
		if (push)
			store[wr_ptr] <= in_data_in;
	end

	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wr_ptr <= {PW{1'b0}};
			rd_ptr <= {PW{1'b0}};
			count  <= {(PW+1){1'b0}};
		end else begin
			if (push)
				wr_ptr <= (wr_ptr == DEPTH[PW-1:0] - 1'b1) ?
					{PW{1'b0}} : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == DEPTH[PW-1:0] - 1'b1) ?
					{PW{1'b0}} : rd_ptr + 1'b1;
			if (push & !pop)
				count <= count + 1'b1;
			else if (pop & !push)
				count <= count - 1'b1;
		end
	end
endmodule
`default_nettype wire

// File: serial_eeprom_i2c_slave_sva.sv
// pin-level assertions for the two-wire eeprom slave
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_i2c_slave_sva #(
	parameter WRITE_CYCLES = 50
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic reset_n_in,
	// bus and straps
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe_n_out,
	input wire logic chip_select_pin_0_in,
	input wire logic chip_select_pin_1_in,
	input wire logic chip_select_pin_2_in,
	input wire logic write_protect_in,
	// status
	input wire logic standby_out,
	input wire logic busy_out
);
	int busy_cnt;
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			busy_cnt <= 0;
		else if (busy_out)
			busy_cnt <= busy_cnt + 1;
		else
			busy_cnt <= 0;
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	sequence s_prog_begin;
		$rose(busy_out);
	endsequence
	sequence s_prog_end;
		$fell(busy_out);
	endsequence
	a_open_drain: assert property (sda_out == 1'b0)
		else $error("data drive value not low");
	a_drive_scl_low: assert property ($changed(sda_oe_n_out) |-> !scl_in)
		else $error("data drive changed while clock high");
	a_quiet_busy: assert property (
		busy_out && $past(busy_out) |-> sda_oe_n_out)
		else $error("data driven while programming");
	a_prog_time: assert property (
		s_prog_end |-> $past(busy_cnt) >= WRITE_CYCLES)
		else $error("programming too short");
	a_prog_bound: assert property (
		busy_out |-> busy_cnt < WRITE_CYCLES + 400)
		else $error("programming too long");
	a_standby_after: assert property (s_prog_end |-> ##[0:2] standby_out)
		else $error("no standby after programming");
	a_wp_blocks: assert property (
		s_prog_begin |-> !$past(write_protect_in, 4))
		else $error("programming under write protect");
	a_standby_quiet: assert property (standby_out |-> sda_oe_n_out)
		else $error("data driven in standby");
	a_reset_state: assert property (disable iff (1'b0)
		!reset_n_in |-> sda_oe_n_out && standby_out && !busy_out)
		else $error("wrong state in reset");
endmodule
bind serial_eeprom_i2c_slave serial_eeprom_i2c_slave_sva #(
	.WRITE_CYCLES(WRITE_CYCLES)
) i_serial_eeprom_i2c_slave_sva (
	.clk_in(clk_in),
	.reset_n_in(reset_n_in),
	.scl_in(scl_in),
	.sda_in(sda_in),
	.sda_out(sda_out),
	.sda_oe_n_out(sda_oe_n_out),
	.chip_select_pin_0_in(chip_select_pin_0_in),
	.chip_select_pin_1_in(chip_select_pin_1_in),
	.chip_select_pin_2_in(chip_select_pin_2_in),
	.write_protect_in(write_protect_in),
	.standby_out(standby_out),
	.busy_out(busy_out)
);
`default_nettype wire

// File: master_model.sv
// bus master model: drives clock and open-drain data
`timescale 1ns/1ps
`default_nettype none
module master_model (
	// bus lines
	output logic      scl_out,
	output logic      sda_out,
	input  wire logic sda_in
);
	// clock stands high between frames; clock low phase is 200 ns
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	task automatic start();
		#120 sda_out = 1'b1;
		#80 scl_out = 1'b1;
		#120 sda_out = 1'b0;
		#120 scl_out = 1'b0;
	endtask
	task automatic stop();
		#120 sda_out = 1'b0;
		#80 scl_out = 1'b1;
		#120 sda_out = 1'b1;
		#120;
	endtask
	task automatic put_bit(input logic b);
		#120 sda_out = b;
		#80 scl_out = 1'b1;
		#120 scl_out = 1'b0;
	endtask
	task automatic get_bit(output logic b);
		#120 sda_out = 1'b1;
		#80 scl_out = 1'b1;
		#60 b = sda_in;
		#60 scl_out = 1'b0;
	endtask
	task automatic send(input logic [7:0] d, output logic ack);
		logic nak;
		for (int i = 7; i >= 0; i--)
			put_bit(d[i]);
		get_bit(nak);
		ack = !nak;
	endtask
	task automatic recv(output logic [7:0] d, input logic more);
		for (int i = 7; i >= 0; i--)
			get_bit(d[i]);
		put_bit(!more);
	endtask
	// up to nine clocks until data is seen high, then caller starts
	task automatic recover();
		logic b;
		for (int i = 0; i < 9; i++) begin
			get_bit(b);
			if (b)
				break;
		end
	endtask
endmodule
`default_nettype wire

// File: testbench.sv
// self-checking bench for the two-wire eeprom slave
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_regs.vh"
module testbench;
	logic clk_in = 1'b0;
	logic reset_n_in = 1'b1;
	logic wp = 1'b0;
	logic cs0 = 1'b1;
	logic cs1 = 1'b0;
	logic cs2 = 1'b1;
	wire  scl, sda_m, sda_oe_n, sda_drv, standby, busy;
	wire  sda = sda_m & sda_oe_n;
	int   n_fail = 0;
	int   n_checks = 0;
	int   cyc = 0;
	localparam logic [7:0] DEV = {`EE_DEV_TYPE, 3'b101, 1'b0};
	localparam logic [7:0] BAD = {`EE_DEV_TYPE, 3'b100, 1'b0};
	always #20 clk_in = ~clk_in;
	serial_eeprom_i2c_slave #(
		.BLOCK_BITS(0),
		.WRITE_CYCLES(200),
		.FIFO_DEPTH(8)
	) i_serial_eeprom_i2c_slave (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.scl_in(scl),
		.sda_in(sda),
		.sda_out(sda_drv),
		.sda_oe_n_out(sda_oe_n),
		.chip_select_pin_0_in(cs0),
		.chip_select_pin_1_in(cs1),
		.chip_select_pin_2_in(cs2),
		.write_protect_in(wp),
		.standby_out(standby),
		.busy_out(busy)
	);
	master_model i_master_model (
		.scl_out(scl),
		.sda_out(sda_m),
		.sda_in(sda)
	);
	task automatic test_done();
		if (n_fail == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, d0, d1, input int n);
		logic k;
		i_master_model.start();
		i_master_model.send(DEV, k);
		chk({7'h00, k}, 8'h01);
		i_master_model.send(a, k);
		chk({7'h00, k}, 8'h01);
		i_master_model.send(d0, k);
		chk({7'h00, k}, 8'h01);
		if (n > 1) begin
			i_master_model.send(d1, k);
			chk({7'h00, k}, 8'h01);
		end
		i_master_model.stop();
	endtask
	task automatic rd(input logic [7:0] a, e0, e1, input int n);
		logic       k;
		logic [7:0] d;
		i_master_model.start();
		i_master_model.send(DEV, k);
		i_master_model.send(a, k);
		i_master_model.start();
		i_master_model.send(DEV | 8'h01, k);
		chk({7'h00, k}, 8'h01);
		i_master_model.recv(d, n > 1);
		chk(d, e0);
		if (n > 1) begin
			i_master_model.recv(d, 1'b0);
			chk(d, e1);
		end
		i_master_model.stop();
	endtask
	task automatic wait_prog();
		for (int i = 0; i < 2000 && busy !== 1'b0; i++) begin
			@(posedge clk_in);
			#1;
		end
		chk({7'h00, busy}, 8'h00);
		chk({7'h00, standby}, 8'h01);
	endtask
	task automatic t_power();
		chk({7'h00, standby}, 8'h01);
		chk({7'h00, busy}, 8'h00);
	endtask
	task automatic t_page();
		logic k;
		wr(8'hFF, 8'h3C, 8'hC3, 2);
		i_master_model.start();
		i_master_model.send(DEV, k);
		chk({7'h00, k}, 8'h00);
		chk({7'h00, busy}, 8'h01);
		i_master_model.stop();
		wait_prog();
		wr(8'h00, 8'h5A, 8'h00, 1);
		wait_prog();
	endtask
	task automatic t_read();
		logic       k;
		logic [7:0] d;
		rd(8'hFF, 8'h3C, 8'h00, 1);
		i_master_model.start();
		i_master_model.send(DEV | 8'h01, k);
		i_master_model.recv(d, 1'b0);
		chk(d, 8'h5A);
		i_master_model.stop();
		rd(8'hF0, 8'hC3, 8'h00, 1);
		rd(8'hFF, 8'h3C, 8'h5A, 2);
	endtask
	task automatic t_wp();
		@(posedge clk_in);
		#1 wp = 1'b1;
		wr(8'h00, 8'hA5, 8'h00, 1);
		repeat (20) @(posedge clk_in);
		#1 chk({7'h00, busy}, 8'h00);
		wp = 1'b0;
		rd(8'h00, 8'h5A, 8'h00, 1);
	endtask
	task automatic t_nomatch();
		logic k;
		i_master_model.start();
		i_master_model.send(BAD, k);
		chk({7'h00, k}, 8'h00);
		i_master_model.send(8'h00, k);
		chk({7'h00, k}, 8'h00);
		i_master_model.stop();
		@(posedge clk_in);
		#1 cs1 = 1'b1;
		i_master_model.start();
		i_master_model.send(DEV, k);
		chk({7'h00, k}, 8'h00);
		i_master_model.stop();
		@(posedge clk_in);
		#1 cs1 = 1'b0;
	endtask
	task automatic t_abort();
		logic k;
		i_master_model.start();
		i_master_model.send(DEV, k);
		i_master_model.send(8'h00, k);
		for (int i = 0; i < 4; i++)
			i_master_model.put_bit(1'b1);
		i_master_model.recover();
		i_master_model.start();
		i_master_model.send(DEV, k);
		chk({7'h00, k}, 8'h01);
		i_master_model.stop();
		repeat (20) @(posedge clk_in);
		#1 chk({7'h00, busy}, 8'h00);
	endtask
	// a hang is cut short well past the expected run length
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			test_done();
		end
	end
	initial begin
		// a real falling edge, so the design resets before the first clock
		#1 reset_n_in = 1'b0;
		repeat (6) @(posedge clk_in);
		#1 reset_n_in = 1'b1;
		repeat (4) @(posedge clk_in);
		t_power();
		t_page();
		t_read();
		t_wp();
		t_nomatch();
		t_abort();
		test_done();
	end
endmodule
`default_nettype wire
